/* rtl/card_socket_power_control.sv */
/*
 Card socket power control register bank: power control, interrupt and
 general control, and the revision nibble that picks the register layout.
 Assumes resets and access strobes come from logic on the same clock;
 card detect pins are asynchronous and are synchronised here.
*/
// How it works
// - Bit 7 drives card_output_enable only, gating no other output
// - Native bit 6 reads zero
// - Native bit 5 enables auto switching
// - Native bit 4 enables Vcc, level selected
// - Native bits 3:2 read zero
// - Native bits 1:0 request Vpp
// - Vpp ignored while Vcc disabled
// - Legacy bits 6:5 zero, writes ignored
// - Legacy bits 4:3 request Vcc level
// - Legacy bit 2 zero, writes ignored
// - Legacy Vpp valid only with Vcc on
// - Sticky bits keep through bus reset while power events are enabled
// - General control register fully read/write
// - Bit 6 releases card reset
// - Bit 5 records card kind
// - Power status mirrors programmed power
// - Revision 0010b selects legacy layout
`timescale 1ns/10ps

module card_socket_power_control (
	input  wire logic                         clock,
	input  wire logic                         srst,
	input  wire logic                         clk_en,
	input  wire logic                         bus_reset,
	input  wire logic                         power_event_enable,
	input  wire logic                         vcc_level_select,
	input  wire socket_power_pkg::reg_access_t access,
	input  wire logic [1:0]                   card_detect_n,
	output logic [7:0]                        rdata,
	output logic                              card_output_enable,
	output logic                              card_reset_n,
	output logic                              card_kind,
	output logic                              socket_power_status,
	output socket_power_pkg::supply_req_t     supply_req
);

	typedef struct packed {
		logic [7:0]                    power;
		logic [7:0]                    irq_gen;
		logic [3:0]                    rev;
		logic [1:0]                    cd_meta;
		logic [1:0]                    cd_sync;
		logic [7:0]                    rdata;
		logic                          out_en;
		logic                          rst_n;
		logic                          kind;
		logic                          pwr_stat;
		socket_power_pkg::supply_req_t req;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// Detect flops start at the empty-socket level, so no false insertion follows reset
	localparam state_t STATE_AT_RESET = '{
		power:    socket_power_pkg::POWER_RESET,
		irq_gen:  socket_power_pkg::IRQ_RESET,
		rev:      socket_power_pkg::REV_RESET,
		cd_meta:  socket_power_pkg::DETECT_IDLE,
		cd_sync:  socket_power_pkg::DETECT_IDLE,
		rdata:    8'h00,
		out_en:   1'b0,
		rst_n:    1'b0,
		kind:     1'b0,
		pwr_stat: 1'b0,
		req:      '0
	};

	// Legacy layout check, used by decode, write and read paths
	function automatic logic is_legacy(input logic [3:0] rev);
		is_legacy = (rev == socket_power_pkg::REV_LEGACY);
	endfunction

	// Decode a power control byte into a supply request
	function automatic socket_power_pkg::supply_req_t decode_power(
		input logic [7:0] pwr,
		input logic       legacy,
		input logic       level_sel,
		input logic       auto_ok
	);
		logic [1:0] vcc;
		logic [1:0] vpp;
		decode_power = '0;
		vcc = pwr[socket_power_pkg::LEG_VCC_LO +: 2];
		vpp = pwr[socket_power_pkg::VPP_LO +: 2];
		if (legacy) begin
			// Legacy Vcc decode
			// Reserved code 01 falls through to off, like 00
			decode_power.vcc_on     = (vcc == socket_power_pkg::VCC_5V) || (vcc == socket_power_pkg::VCC_3V3);
			decode_power.vcc_is_3v3 = (vcc == socket_power_pkg::VCC_3V3);
		end else begin
			decode_power.vcc_on     = pwr[socket_power_pkg::BIT_VCC_EN] && auto_ok;
			decode_power.vcc_is_3v3 = level_sel;
		end
		if (decode_power.vcc_on && (vpp == socket_power_pkg::VPP_VCC || vpp == socket_power_pkg::VPP_12V)) begin
			decode_power.vpp_sel = vpp;
		end else begin
			decode_power.vpp_sel = socket_power_pkg::VPP_OFF;
		end
	endfunction

	// Next state: register writes, decode and output staging
	always_comb begin
		logic                          legacy;
		logic                          auto_ok;
		logic [7:0]                    mask;
		socket_power_pkg::supply_req_t programmed;
		legacy     = 1'b0;
		auto_ok    = 1'b0;
		mask       = 8'h00;
		programmed = '0;
		state_next = state_reg;

		// Detect pins pass two flops before use
		state_next.cd_meta = card_detect_n;
		state_next.cd_sync = state_reg.cd_meta;

		legacy = is_legacy(state_reg.rev);
		mask = legacy ? socket_power_pkg::LEGACY_MASK : socket_power_pkg::NATIVE_MASK;

		if (access.wr) begin
			case (access.addr)
				socket_power_pkg::OFFS_IDENT: begin
					state_next.rev = access.wdata[3:0];
				end
				socket_power_pkg::OFFS_POWER: begin
					state_next.power = access.wdata & mask;
				end
				socket_power_pkg::OFFS_IRQ_GEN: begin
					state_next.irq_gen = access.wdata;
				end
				default: begin
				end
			endcase
		end

		// Re-mask on a layout change so stale reserved bits never read back
		state_next.power = state_next.power & (is_legacy(state_next.rev) ?
			socket_power_pkg::LEGACY_MASK : socket_power_pkg::NATIVE_MASK);

		// Auto switch needs card seated
		// Both detects must be low: a half-seated card gets no Vcc
		auto_ok = !state_reg.power[socket_power_pkg::BIT_AUTO_SW] || (state_reg.cd_sync == 2'h0);

		state_next.req = decode_power(state_reg.power, legacy, vcc_level_select, auto_ok);

		state_next.out_en = state_reg.power[socket_power_pkg::BIT_OUT_EN];
		state_next.rst_n  = state_reg.irq_gen[socket_power_pkg::BIT_CARD_RST];
		state_next.kind   = state_reg.irq_gen[socket_power_pkg::BIT_CARD_KND];
		// Power status from programming
		// Status ignores the detect pins so software sees what it asked for
		programmed          = decode_power(state_reg.power, legacy, vcc_level_select, 1'b1);
		state_next.pwr_stat = programmed.vcc_on;

		// Read data registered one cycle after the read strobe
		// Unmapped offsets and idle cycles return zero, never stale data
		state_next.rdata = 8'h00;
		if (access.rd) begin
			case (access.addr)
				socket_power_pkg::OFFS_IDENT:   state_next.rdata = {4'h0, state_reg.rev};
				socket_power_pkg::OFFS_STATUS:  state_next.rdata = {1'b0, state_reg.pwr_stat, 6'h00};
				socket_power_pkg::OFFS_POWER:   state_next.rdata = state_reg.power & mask;
				socket_power_pkg::OFFS_IRQ_GEN: state_next.rdata = state_reg.irq_gen;
				default:                        state_next.rdata = 8'h00;
			endcase
		end

		// Bus reset spares sticky bits only while power_event_enable is high, else loads reset values
		// Bus reset wins over a same-cycle write, so the stored bytes are the source.
		// The layout is kept with the sticky bits: a kept 3.3 V code would otherwise
		// decode as 5 V once the native mask strips bit 3.
		if (bus_reset) begin
			if (power_event_enable) begin
				state_next.rev     = state_reg.rev;
				state_next.power   = state_reg.power & (legacy ?
					socket_power_pkg::STICKY_LEGACY : socket_power_pkg::STICKY_NATIVE);
				state_next.irq_gen = state_reg.irq_gen & socket_power_pkg::STICKY_IRQ;
			end else begin
				state_next.rev     = socket_power_pkg::REV_RESET;
				state_next.power   = socket_power_pkg::POWER_RESET;
				state_next.irq_gen = socket_power_pkg::IRQ_RESET;
			end
		end
	end

	// Global reset loads the reset state (revision 4, detect flops idle high); clock enable freezes all state
	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= STATE_AT_RESET;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign rdata               = state_reg.rdata;
	assign card_output_enable  = state_reg.out_en;
	assign card_reset_n        = state_reg.rst_n;
	assign card_kind           = state_reg.kind;
	assign socket_power_status = state_reg.pwr_stat;
	assign supply_req          = state_reg.req;

endmodule

/* rtl/socket_power_pkg.sv */
/*
 Package for the card socket power control register bank: byte offsets,
 field positions, reset values and supply encodings, plus the carrier structs.
 Assumes a byte-wide register access port on the socket base address.
*/
package socket_power_pkg;

	// Byte offsets relative to the socket base address
	localparam logic [11:0] OFFS_IDENT     = 12'h800;
	localparam logic [11:0] OFFS_STATUS    = 12'h801;
	localparam logic [11:0] OFFS_POWER     = 12'h802;
	localparam logic [11:0] OFFS_IRQ_GEN   = 12'h803;

	// Power control, power status and general control fields
	localparam int BIT_OUT_EN   = 7;
	localparam int BIT_AUTO_SW  = 5;
	localparam int BIT_VCC_EN   = 4;
	localparam int LEG_VCC_LO   = 3;
	localparam int VPP_LO       = 0;
	localparam int BIT_PWR_STAT = 6;
	localparam int BIT_CARD_RST = 6;
	localparam int BIT_CARD_KND = 5;

	// Reset values and the legacy revision code
	localparam logic [7:0] POWER_RESET  = 8'h00;
	localparam logic [7:0] IRQ_RESET    = 8'h00;
	localparam logic [3:0] REV_RESET    = 4'h4;
	localparam logic [3:0] REV_LEGACY   = 4'h2;

	// Write masks: only these bits hold state in each layout
	localparam logic [7:0] NATIVE_MASK  = 8'hb3;
	localparam logic [7:0] LEGACY_MASK  = 8'h9b;

	// Bits that survive a bus reset while power events are enabled
	localparam logic [7:0] STICKY_NATIVE = 8'h20;
	localparam logic [7:0] STICKY_LEGACY = 8'h9b;
	localparam logic [7:0] STICKY_IRQ    = 8'h60;

	// Detect pins have pull-ups, so an empty socket reads high
	localparam logic [1:0] DETECT_IDLE   = 2'h3;

	// Supply encodings
	localparam logic [1:0] VPP_OFF      = 2'h0;
	localparam logic [1:0] VPP_VCC      = 2'h1;
	localparam logic [1:0] VPP_12V      = 2'h2;
	localparam logic [1:0] VCC_0V       = 2'h0;
	localparam logic [1:0] VCC_5V       = 2'h2;
	localparam logic [1:0] VCC_3V3      = 2'h3;

	// Supply request toward the external power switch
	typedef struct packed {
		logic       vcc_on;
		logic       vcc_is_3v3;
		logic [1:0] vpp_sel;
	} supply_req_t;

	// Register access strobe group
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} reg_access_t;

endpackage

/* verification/socket_card_model.sv */
/* Far side of the bank: the card sitting in the socket.
 Assumes the bench says when a card is inserted. */
`timescale 1ns/10ps
module socket_card_model (
	input wire logic  inserted,
	output logic [1:0] card_detect_n
);
	// Detect pins have pull-ups, so an empty socket reads high
	assign card_detect_n = inserted ? 2'h0 : 2'h3;
endmodule

/* verification/socket_power_sva.sv */
/* Assertions on the socket power bank ports.
 Assumes binding to the bank top, one clock, srst as reset. */
`timescale 1ns/10ps
module socket_power_sva (
	input wire logic                          clock,
	input wire logic                          srst,
	input wire logic                          clk_en,
	input wire logic                          bus_reset,
	input wire socket_power_pkg::reg_access_t access,
	input wire logic [7:0]                    rdata,
	input wire logic                          card_output_enable,
	input wire logic                          card_reset_n,
	input wire logic                          card_kind,
	input wire logic                          socket_power_status,
	input wire socket_power_pkg::supply_req_t supply_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Write taken at one offset, then a live edge so the output copy lands
	sequence s_wr(a);
		access.wr && clk_en && !bus_reset && access.addr == a ##1 clk_en;
	endsequence
	property p_coe;
		s_wr(socket_power_pkg::OFFS_POWER) |=> card_output_enable == $past(access.wdata[7], 2);
	endproperty
	a_coe: assert property (p_coe) else $error("output enable differs from write");
	property p_crst;
		s_wr(socket_power_pkg::OFFS_IRQ_GEN) |=> card_reset_n == $past(access.wdata[6], 2);
	endproperty
	a_crst: assert property (p_crst) else $error("card reset differs from write");
	property p_kind;
		s_wr(socket_power_pkg::OFFS_IRQ_GEN) |=> card_kind == $past(access.wdata[5], 2);
	endproperty
	a_kind: assert property (p_kind) else $error("card kind differs from write");
	property p_rsvd;
		access.rd && clk_en && access.addr == socket_power_pkg::OFFS_POWER |=> rdata[6] == 1'b0 && rdata[2] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved power bit read high");
	property p_gate;
		!supply_req.vcc_on |-> supply_req.vpp_sel == 2'h0;
	endproperty
	a_gate: assert property (p_gate) else $error("vpp applied without vcc");
	property p_vpp11;
		supply_req.vpp_sel != 2'h3;
	endproperty
	a_vpp11: assert property (p_vpp11) else $error("reserved vpp code applied");
	property p_stat;
		supply_req.vcc_on |-> socket_power_status;
	endproperty
	a_stat: assert property (p_stat) else $error("power status low with vcc on");
	property p_rst;
		$fell(srst) |-> !card_output_enable && !card_reset_n && !card_kind && supply_req == 4'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not at reset value");
	c_3v3: cover property (supply_req.vcc_on && supply_req.vcc_is_3v3);
	c_12v: cover property (supply_req.vpp_sel == 2'h2);
	c_rd: cover property (access.rd ##1 rdata != 8'h00);
endmodule
bind card_socket_power_control socket_power_sva socket_power_sva_i (.*);

/* verification/testbench.sv */
/* Self-checking bench for the socket power bank.
 Assumes the card model and the checker are compiled before it. */
`timescale 1ns/10ps
module testbench;
	logic                          clock, srst, bus_reset, power_event_enable, vcc_level_select, inserted, lg;
	logic                          card_output_enable, card_reset_n, card_kind, socket_power_status;
	logic                          clk_en = 1'b1;
	logic [1:0]                    card_detect_n;
	logic [7:0]                    rdata, pw;
	logic [31:0]                   seed;
	int                            mismatches, compares;
	socket_power_pkg::reg_access_t access;
	socket_power_pkg::supply_req_t supply_req;
	card_socket_power_control card_socket_power_control_i (
		.clock               (clock),
		.srst                (srst),
		.clk_en              (clk_en),
		.bus_reset           (bus_reset),
		.power_event_enable  (power_event_enable),
		.vcc_level_select    (vcc_level_select),
		.access              (access),
		.card_detect_n       (card_detect_n),
		.rdata               (rdata),
		.card_output_enable  (card_output_enable),
		.card_reset_n        (card_reset_n),
		.card_kind           (card_kind),
		.socket_power_status (socket_power_status),
		.supply_req          (supply_req)
	);
	socket_card_model socket_card_model_i (.inserted(inserted), .card_detect_n(card_detect_n));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Switch request; legacy level follows bit 3 only while vcc is on, native level is the select input
	function automatic logic [7:0] exp_sup(input logic [7:0] p, input logic l, input logic v, input logic c);
		logic on;
		on = l ? p[4] : p[4] && (!p[5] || c);
		return {4'h0, on, l ? on & p[3] : v, (on && p[1:0] != 2'h3) ? p[1:0] : 2'h0};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One byte access, launched just after an edge and taken at the next one;
	// it stays up until the next call replaces it or the bench clears it
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
		access = {w, !w, a, d};
		@(posedge clock);
		#1;
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog in case the sequence hangs
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		report_and_stop();
	end
	initial begin
		{srst, bus_reset, power_event_enable, vcc_level_select, inserted} = 5'h10;
		access = '0;
		seed = 32'h9c87;
		repeat (12) @(posedge clock);
		#1 srst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, 12'h800 + i[11:0], 8'h00);
			chk(rdata, i == 0 ? 8'h04 : 8'h00);
		end
		// Random layout, level, presence and register contents
		for (int n = 0; n < 80; n++) begin
			seed = lfsr(seed);
			{inserted, vcc_level_select, lg} = seed[10:8];
			acc(1'b1, 12'h800, lg ? 8'h02 : 8'h04);
			acc(1'b1, 12'h802, seed[7:0]);
			acc(1'b1, 12'h803, seed[23:16]);
			pw = seed[7:0] & (lg ? 8'h9b : 8'hb3);
			acc(1'b0, 12'h802, 8'h00);
			chk(rdata, pw);
			acc(1'b0, 12'h803, 8'h00);
			chk(rdata, seed[23:16]);
			chk({4'h0, card_output_enable, card_reset_n, card_kind, socket_power_status}, {4'h0, pw[7], seed[22:21], pw[4]});
			chk({4'h0, supply_req}, exp_sup(pw, lg, vcc_level_select, inserted));
		end
		// Bus reset: legacy with power events, native with them, native without
		for (int k = 2; k >= 0; k--) begin
			acc(1'b1, 12'h800, k == 2 ? 8'h02 : 8'h04);
			acc(1'b1, 12'h802, 8'hff);
			acc(1'b1, 12'h803, 8'hff);
			power_event_enable = (k != 0);
			bus_reset = 1'b1;
			access = '0;
			@(posedge clock);
			#1 bus_reset = 1'b0;
			acc(1'b0, 12'h802, 8'h00);
			chk(rdata, k == 2 ? 8'h9b : (k == 1 ? 8'h20 : 8'h00));
			acc(1'b0, 12'h803, 8'h00);
			chk(rdata, k != 0 ? 8'h60 : 8'h00);
		end
		// Global reset mid-run clears a programmed socket
		acc(1'b1, 12'h802, 8'h90);
		acc(1'b0, 12'h802, 8'h00);
		chk(rdata, 8'h90);
		srst = 1'b1;
		access = '0;
		@(posedge clock);
		#1 srst = 1'b0;
		acc(1'b0, 12'h802, 8'h00);
		chk(rdata, 8'h00);
		chk({4'h0, card_output_enable, card_reset_n, card_kind, socket_power_status}, 8'h00);
		// A write while the clock enable is low must not land
		clk_en = 1'b0;
		acc(1'b1, 12'h803, 8'h5a);
		clk_en = 1'b1;
		acc(1'b0, 12'h803, 8'h00);
		chk(rdata, 8'h00);
		report_and_stop();
	end
endmodule
